// File: core/tuam_pkg.sv
// package of the layer-4 access rule entry matcher: register map, field layout,
// encodings and the frame carrier.
// assumes apb byte addressing with one 32-bit word per register.
package tuam_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_SRC_RANGE = 8'h04;
  localparam logic [7:0] ADDR_DST_RANGE = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0c;
  localparam logic [7:0] ADDR_HIT_CNT   = 8'h10;
  localparam logic [7:0] ADDR_MISS_CNT  = 8'h14;

  // control register field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_SRC_LSB  = 1;
  localparam int CTRL_DST_LSB  = 3;
  localparam int CTRL_FLAG_LSB = 5;
  localparam int CTRL_WIDTH    = 11;

  // range register halves
  localparam int RANGE_LO_LSB = 0;
  localparam int RANGE_HI_LSB = 16;

  // port filter mode selector
  typedef enum logic [1:0] {
    TUAM_PORT_ANY   = 2'h0,
    TUAM_PORT_EXACT = 2'h1,
    TUAM_PORT_RANGE = 2'h2,
    TUAM_PORT_RSVD  = 2'h3
  } tuam_port_mode_t;

  // tcp flag condition; code 3 behaves as don't-care
  typedef enum logic [1:0] {
    TUAM_FLAG_ANY = 2'h0,
    TUAM_FLAG_CLR = 2'h1,
    TUAM_FLAG_SET = 2'h2,
    TUAM_FLAG_AN2 = 2'h3
  } tuam_flag_cond_t;

  // flag order inside the flags vector and the control field
  localparam int FLAG_FIN = 0;
  localparam int FLAG_SYN = 1;
  localparam int FLAG_PSH = 2;
  localparam int NUM_FLAGS = 3;

  // reset values: entry disabled, every condition don't-care
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET  = 11'h000;
  localparam logic [31:0]           RANGE_RESET = 32'h0000_0000;

  typedef struct packed {
    logic                 is_l4;
    logic                 is_tcp;
    logic [15:0]          src_port;
    logic [15:0]          dst_port;
    logic [NUM_FLAGS-1:0] flags;
  } tuam_frame_t;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } tuam_range_t;

endpackage : tuam_pkg

// File: core/tuam_port_cmp.sv
// one port filter of the access rule entry: don't-care, exact or inclusive range.
// assumes the port value and settings are stable in the cycle they are compared.
`timescale 1ns/1ns
`default_nettype none
module tuam_port_cmp (
  input  wire logic                      l4_valid,
  input  wire tuam_pkg::tuam_port_mode_t mode,
  input  wire tuam_pkg::tuam_range_t     bounds,
  input  wire logic [15:0]               port,
  output logic                           hit
);

  logic exact_hit;
  logic range_hit;

  assign exact_hit = port == bounds.lo;
  // inclusive both ends; lo above hi matches nothing
  assign range_hit = (port >= bounds.lo) && (port <= bounds.hi);

  always_comb begin
    case (mode)
      tuam_pkg::TUAM_PORT_ANY:   hit = 1'b1;
      tuam_pkg::TUAM_PORT_EXACT: hit = l4_valid && exact_hit;
      tuam_pkg::TUAM_PORT_RANGE: hit = l4_valid && range_hit;
      default:                   hit = 1'b0;
    endcase
  end

endmodule : tuam_port_cmp
`default_nettype wire

// File: core/tuam_matcher.sv
// one access_rule_entry of the layer-4 classifier, with its apb register file.
// assumes frame fields come from parser logic on CLK, one frame per FRAME_VALID.
//
// Overview of operation
// - source port don't-care matches every frame
// - exact source mode compares full 16 bits
// - source range mode, bounds 0 to 65535
// - destination port don't-care matches every frame
// - exact destination mode compares full 16 bits
// - destination range mode, bounds 0 to 65535
// - FIN condition: clear, set or don't-care
// - SYN condition: clear, set or don't-care
// - PSH condition: clear or set
// - each port filter has two-bit mode
// - PSH condition also has don't-care
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module tuam_matcher (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  FRAME_VALID,
  input  wire tuam_pkg::tuam_frame_t FRAME,
  output logic                       MATCH_VALID,
  output logic                       MATCH
);

  // ---------------- apb decode ----------------
  logic        acc;
  logic        wr_acc;
  logic        sel_ctrl;
  logic        sel_src;
  logic        sel_dst;
  logic        sel_stat;
  logic        sel_hit;
  logic        sel_miss;
  logic        mapped;
  logic [31:0] wmask;

  assign acc      = PSEL && PENABLE;
  assign sel_ctrl = PADDR == tuam_pkg::ADDR_CTRL;
  assign sel_src  = PADDR == tuam_pkg::ADDR_SRC_RANGE;
  assign sel_dst  = PADDR == tuam_pkg::ADDR_DST_RANGE;
  assign sel_stat = PADDR == tuam_pkg::ADDR_STATUS;
  assign sel_hit  = PADDR == tuam_pkg::ADDR_HIT_CNT;
  assign sel_miss = PADDR == tuam_pkg::ADDR_MISS_CNT;
  assign mapped   = sel_ctrl || sel_src || sel_dst || sel_stat || sel_hit || sel_miss;
  assign wr_acc   = acc && PWRITE && mapped;

  // zero wait states keep the match path free of bus stalls
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !mapped;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign wmask[lane*8 +: 8] = {8{PSTRB[lane]}};
    end
  endgenerate

  // ---------------- configuration registers ----------------
  logic [tuam_pkg::CTRL_WIDTH-1:0] ctrl_q;
  logic [tuam_pkg::CTRL_WIDTH-1:0] ctrl_d;
  logic [31:0]                     src_q;
  logic [31:0]                     src_d;
  logic [31:0]                     dst_q;
  logic [31:0]                     dst_d;
  logic [31:0]                     ctrl_word;

  assign ctrl_word = {{(32 - tuam_pkg::CTRL_WIDTH){1'b0}}, ctrl_q};
  assign ctrl_d    = 11'((ctrl_word & ~wmask) | (PWDATA & wmask));
  assign src_d     = (src_q & ~wmask) | (PWDATA & wmask);
  assign dst_d     = (dst_q & ~wmask) | (PWDATA & wmask);

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= tuam_pkg::CTRL_RESET;
    end else if (wr_acc && sel_ctrl) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      src_q <= tuam_pkg::RANGE_RESET;
    end else if (wr_acc && sel_src) begin
      src_q <= src_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      dst_q <= tuam_pkg::RANGE_RESET;
    end else if (wr_acc && sel_dst) begin
      dst_q <= dst_d;
    end
  end

  // ---------------- field extraction ----------------
  logic                      entry_en;
  tuam_pkg::tuam_port_mode_t src_mode;
  tuam_pkg::tuam_port_mode_t dst_mode;
  tuam_pkg::tuam_range_t     src_bounds;
  tuam_pkg::tuam_range_t     dst_bounds;

  assign entry_en = ctrl_q[tuam_pkg::CTRL_EN_BIT];
  // two-bit selector per port filter
  assign src_mode = tuam_pkg::tuam_port_mode_t'(ctrl_q[tuam_pkg::CTRL_SRC_LSB +: 2]);
  assign dst_mode = tuam_pkg::tuam_port_mode_t'(ctrl_q[tuam_pkg::CTRL_DST_LSB +: 2]);

  // full 16-bit bounds, so 0 and 65535 are both reachable
  assign src_bounds.lo = src_q[tuam_pkg::RANGE_LO_LSB +: 16];
  assign src_bounds.hi = src_q[tuam_pkg::RANGE_HI_LSB +: 16];
  assign dst_bounds.lo = dst_q[tuam_pkg::RANGE_LO_LSB +: 16];
  assign dst_bounds.hi = dst_q[tuam_pkg::RANGE_HI_LSB +: 16];

  // ---------------- port filters ----------------
  logic src_hit;
  logic dst_hit;

  // don't-care, exact and range handled in the comparator
  tuam_port_cmp u_src_cmp (
    .l4_valid (FRAME.is_l4),
    .mode     (src_mode),
    .bounds   (src_bounds),
    .port     (FRAME.src_port),
    .hit      (src_hit)
  );

  // same comparator on the destination side
  tuam_port_cmp u_dst_cmp (
    .l4_valid (FRAME.is_l4),
    .mode     (dst_mode),
    .bounds   (dst_bounds),
    .port     (FRAME.dst_port),
    .hit      (dst_hit)
  );

  // ---------------- tcp flag conditions ----------------
  // a non-tcp frame carries no flags, so it fails any condition that is not don't-care
  logic [tuam_pkg::NUM_FLAGS-1:0] flag_ok;

  genvar fi;
  generate
    for (fi = 0; fi < tuam_pkg::NUM_FLAGS; fi = fi + 1) begin : g_flag
      tuam_pkg::tuam_flag_cond_t cond;
      logic                      need_clr;
      logic                      need_set;
      assign cond     = tuam_pkg::tuam_flag_cond_t'(ctrl_q[tuam_pkg::CTRL_FLAG_LSB + 2*fi +: 2]);
      assign need_clr = cond == tuam_pkg::TUAM_FLAG_CLR;
      assign need_set = cond == tuam_pkg::TUAM_FLAG_SET;
      // 1 keeps flag-set frames out, 2 admits only them, others ignore
      assign flag_ok[fi] = (!need_clr && !need_set)
                        || (need_clr && FRAME.is_tcp && !FRAME.flags[fi])
                        || (need_set && FRAME.is_tcp && FRAME.flags[fi]);
    end
  endgenerate

  // ---------------- entry verdict ----------------
  logic all_hit;

  // every condition must hold together
  assign all_hit = entry_en && src_hit && dst_hit && (&flag_ok);

  logic match_valid_q;
  logic match_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      match_valid_q <= 1'b0;
      match_q       <= 1'b0;
    end else begin
      match_valid_q <= FRAME_VALID;
      match_q       <= FRAME_VALID && all_hit;
    end
  end

  assign MATCH_VALID = match_valid_q;
  assign MATCH       = match_q;

  // ---------------- status and counters ----------------
  logic        last_match_q;
  logic        seen_q;
  logic [31:0] hit_cnt_q;
  logic [31:0] hit_cnt_d;
  logic [31:0] miss_cnt_q;
  logic [31:0] miss_cnt_d;
  logic        hit_evt;
  logic        miss_evt;
  logic        clr_hit;
  logic        clr_miss;

  assign hit_evt  = FRAME_VALID && all_hit;
  assign miss_evt = FRAME_VALID && !all_hit;
  assign clr_hit  = wr_acc && sel_hit;
  assign clr_miss = wr_acc && sel_miss;

  // a frame in the clearing cycle still counts, so no event is lost
  assign hit_cnt_d  = clr_hit ? {31'h0000_0000, hit_evt} : hit_cnt_q + {31'h0000_0000, hit_evt};
  assign miss_cnt_d = clr_miss ? {31'h0000_0000, miss_evt} : miss_cnt_q + {31'h0000_0000, miss_evt};

  always_ff @(posedge CLK) begin
    if (RST) begin
      hit_cnt_q  <= 32'h0000_0000;
      miss_cnt_q <= 32'h0000_0000;
    end else begin
      hit_cnt_q  <= hit_cnt_d;
      miss_cnt_q <= miss_cnt_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      last_match_q <= 1'b0;
      seen_q       <= 1'b0;
    end else if (FRAME_VALID) begin
      last_match_q <= all_hit;
      seen_q       <= 1'b1;
    end
  end

  // ---------------- read mux ----------------
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;

  assign status_word = {29'h0000_0000, entry_en, seen_q, last_match_q};

  assign rd_mux = sel_ctrl ? ctrl_word   :
                  sel_src  ? src_q       :
                  sel_dst  ? dst_q       :
                  sel_stat ? status_word :
                  sel_hit  ? hit_cnt_q   :
                  sel_miss ? miss_cnt_q  :
                             32'h0000_0000;

  // read data is captured in the setup cycle so it is a flop during the access phase
  always_ff @(posedge CLK) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_q <= rd_mux;
    end
  end

  assign PRDATA = prdata_q;

endmodule : tuam_matcher
`default_nettype wire

// File: bench/tuam_parser_model.sv
// parser model: hands one frame per send cycle to the entry matcher.
// assumes the bench raises send just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module tuam_parser_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  send,
  input  wire tuam_pkg::tuam_frame_t frm,
  output logic                       valid,
  output tuam_pkg::tuam_frame_t      frame
);
  // idle fields flip every cycle so a stale frame never looks valid
  always_ff @(posedge clk) begin
    valid <= send;
    frame <= rst ? '0 : (send ? frm : ~frame);
  end
endmodule : tuam_parser_model
`default_nettype wire

// File: bench/tuam_matcher_props.sv
// checker of the entry matcher ports.
// assumes full-lane apb writes; shadows the control word from them.
`timescale 1ns/1ns
`default_nettype none
module tuam_matcher_props (
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [7:0]            PADDR,
  input wire logic [31:0]           PWDATA,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  input wire logic                  FRAME_VALID,
  input wire tuam_pkg::tuam_frame_t FRAME,
  input wire logic                  MATCH_VALID,
  input wire logic                  MATCH
);
  logic [10:0] ctl_q;
  wire logic   acc = PSEL && PENABLE;
  wire logic   bad = PADDR > 8'h14 || PADDR[1:0] != 2'h0;
  wire logic   clr = FRAME.is_tcp && ((ctl_q[6:5] == 2'h1 && FRAME.flags[0]) ||
    (ctl_q[8:7] == 2'h1 && FRAME.flags[1]) || (ctl_q[10:9] == 2'h1 && FRAME.flags[2]));
  always_ff @(posedge CLK) begin
    if (RST) ctl_q <= '0;
    else if (acc && PWRITE && PADDR == tuam_pkg::ADDR_CTRL) ctl_q <= PWDATA[10:0];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  strobe_lat_a: assert property (FRAME_VALID |=> MATCH_VALID) else $error("late strobe");
  strobe_idle_a: assert property (!FRAME_VALID |=> !MATCH_VALID) else $error("extra strobe");
  match_qual_a: assert property (MATCH |-> MATCH_VALID) else $error("match without strobe");
  off_miss_a: assert property (FRAME_VALID && !ctl_q[0] |=> !MATCH) else $error("disabled hit");
  all_any_a: assert property (FRAME_VALID && ctl_q == 11'h001 |=> MATCH)
    else $error("don't-care miss");
  flag_clr_a: assert property (FRAME_VALID && clr |=> !MATCH) else $error("flag leak");
  mode_rsvd_a: assert property (FRAME_VALID && (ctl_q[2:1] == 2'h3 || ctl_q[4:3] == 2'h3) |=> !MATCH)
    else $error("reserved mode hit");
  addr_err_a: assert property (acc && bad |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped accepted");
  addr_ok_a: assert property (acc && !bad |-> PREADY && !PSLVERR) else $error("mapped refused");
  cover property (FRAME_VALID ##1 MATCH);
  cover property (FRAME_VALID ##1 !MATCH);
  cover property (acc && PSLVERR);
endmodule : tuam_matcher_props
bind tuam_matcher tuam_matcher_props u_tuam_matcher_props (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAME_VALID(FRAME_VALID), .FRAME(FRAME),
  .MATCH_VALID(MATCH_VALID), .MATCH(MATCH));
`default_nettype wire

// File: bench/tuam_matcher_bench.sv
// bench of the entry matcher: entry table, then back-to-back, refusal and reset.
// assumes a zero-wait apb slave and one match strobe per frame.
`timescale 1ns/1ns
`default_nettype none
module tuam_matcher_bench;
  typedef struct packed {
    logic [31:0]           c;
    logic [31:0]           s;
    logic [31:0]           d;
    tuam_pkg::tuam_frame_t f;
    logic                  e;
  } tuam_row_t;
  logic                  CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, send = 0, er;
  logic [7:0]            PADDR = 8'h0;
  logic [31:0]           PWDATA = 32'h0, PRDATA, rd;
  logic                  PREADY, PSLVERR, FRAME_VALID, MATCH_VALID, MATCH;
  tuam_pkg::tuam_frame_t FRAME, sf = '0;
  tuam_row_t             rows [25];
  int                    miscompares = 0, n_tests = 0, k;
  initial begin
    forever #4 CLK = ~CLK;
  end
  tuam_parser_model u_tuam_parser_model (.clk(CLK), .rst(RST), .send(send), .frm(sf),
    .valid(FRAME_VALID), .frame(FRAME));
  tuam_matcher u_tuam_matcher (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAME_VALID(FRAME_VALID), .FRAME(FRAME),
    .MATCH_VALID(MATCH_VALID), .MATCH(MATCH));
  function automatic tuam_pkg::tuam_frame_t fm(input logic [15:0] s, d, input logic [2:0] g);
    return '{1'b1, 1'b1, s, d, g};
  endfunction : fm
  task conclude();
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task chk(input string n, input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      $display("BAD %s exp %h got %h", n, x, s);
      miscompares++;
    end
  endtask : chk
  // request held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge CLK);
    PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= wd;
    @(posedge CLK) PENABLE <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
    if (i == 8) begin chk("pready", 32'h0, 32'h1); conclude(); end
  endtask : apb
  task fr(input tuam_pkg::tuam_frame_t f, input logic e);
    int i;
    @(posedge CLK); send <= 1'b1; sf <= f;
    @(posedge CLK) send <= 1'b0;
    for (i = 0; i < 6; i++) begin
      @(posedge CLK);
      if (MATCH_VALID === 1'b1) break;
    end
    if (i == 6) begin chk("strobe", 32'h0, 32'h1); conclude(); end
    chk("match", {31'h0, MATCH}, {31'h0, e});
  endtask : fr
  initial begin
    rows = '{'{32'h1, 32'h0, 32'h0, fm(16'h1234, 16'h4321, 3'h7), 1'b1},
      '{32'h3, 32'h0, 32'h0, fm(16'h0, 16'h9, 3'h0), 1'b1},
      '{32'h3, 32'h0, 32'h0, fm(16'h1, 16'h9, 3'h0), 1'b0},
      '{32'h3, 32'hffff, 32'h0, fm(16'hffff, 16'h9, 3'h0), 1'b1},
      '{32'h5, 32'h200010, 32'h0, fm(16'h10, 16'h9, 3'h0), 1'b1},
      '{32'h5, 32'h200010, 32'h0, fm(16'h20, 16'h9, 3'h0), 1'b1},
      '{32'h5, 32'h200010, 32'h0, fm(16'h21, 16'h9, 3'h0), 1'b0},
      '{32'h5, 32'h200010, 32'h0, fm(16'hf, 16'h9, 3'h0), 1'b0},
      '{32'h9, 32'h0, 32'h50, fm(16'h0, 16'h50, 3'h0), 1'b1},
      '{32'h9, 32'h0, 32'h50, fm(16'h0, 16'h51, 3'h0), 1'b0},
      '{32'h11, 32'h0, 32'hffff0000, fm(16'h0, 16'hffff, 3'h0), 1'b1},
      '{32'h11, 32'h0, 32'h60005, fm(16'h0, 16'h7, 3'h0), 1'b0},
      '{32'h21, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h1), 1'b0},
      '{32'h41, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h1), 1'b1},
      '{32'h41, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h0), 1'b0},
      '{32'h81, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h2), 1'b0},
      '{32'h101, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h2), 1'b1},
      '{32'h201, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h4), 1'b0},
      '{32'h401, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h4), 1'b1},
      '{32'h7, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h0), 1'b0},
      '{32'hb, 32'h5, 32'h6, fm(16'h5, 16'h7, 3'h0), 1'b0},
      '{32'h0, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h0), 1'b0},
      '{32'h7e1, 32'h0, 32'h0, fm(16'h0, 16'h0, 3'h5), 1'b1},
      '{32'h3, 32'h0, 32'h0, '{1'b0, 1'b1, 16'h0, 16'h9, 3'h0}, 1'b0},
      '{32'h41, 32'h0, 32'h0, '{1'b1, 1'b0, 16'h0, 16'h0, 3'h1}, 1'b0}};
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, tuam_pkg::ADDR_CTRL, 32'h0); chk("ctrl", rd, 32'h0);
    apb(1'b0, tuam_pkg::ADDR_STATUS, 32'h0); chk("status", rd, 32'h0);
    for (k = 0; k < 25; k++) begin
      apb(1'b1, tuam_pkg::ADDR_CTRL, rows[k].c);
      apb(1'b1, tuam_pkg::ADDR_SRC_RANGE, rows[k].s);
      apb(1'b1, tuam_pkg::ADDR_DST_RANGE, rows[k].d);
      fr(rows[k].f, rows[k].e);
    end
    // two frames on consecutive cycles: one hit, one miss
    apb(1'b1, tuam_pkg::ADDR_CTRL, 32'h3);
    apb(1'b1, tuam_pkg::ADDR_SRC_RANGE, 32'h5);
    apb(1'b1, tuam_pkg::ADDR_HIT_CNT, 32'h0);
    apb(1'b1, tuam_pkg::ADDR_MISS_CNT, 32'h0);
    @(posedge CLK); send <= 1'b1; sf <= fm(16'h5, 16'h1, 3'h0);
    @(posedge CLK) sf <= fm(16'h6, 16'h1, 3'h0);
    @(posedge CLK) send <= 1'b0;
    repeat (4) @(posedge CLK);
    apb(1'b0, tuam_pkg::ADDR_HIT_CNT, 32'h0); chk("hits", rd, 32'h1);
    apb(1'b0, tuam_pkg::ADDR_MISS_CNT, 32'h0); chk("misses", rd, 32'h1);
    apb(1'b0, tuam_pkg::ADDR_STATUS, 32'h0); chk("status", rd, 32'h6);
    apb(1'b0, 8'h18, 32'h0); chk("slverr", {31'h0, er}, 32'h1);
    chk("rdata", rd, 32'h0);
    // reset in mid-run must drop the entry back to disabled and zero the hit counter
    @(posedge CLK) RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, tuam_pkg::ADDR_CTRL, 32'h0); chk("ctrl_rst", rd, 32'h0);
    apb(1'b0, tuam_pkg::ADDR_HIT_CNT, 32'h0); chk("hits_rst", rd, 32'h0);
    apb(1'b0, tuam_pkg::ADDR_STATUS, 32'h0); chk("status_rst", rd, 32'h0);
    fr(fm(16'h5, 16'h1, 3'h0), 1'b0);
    conclude();
  end
endmodule : tuam_matcher_bench
`default_nettype wire
